// *** rtl/bts_pkg.sv ***
package bts_pkg;

    // register port map
    localparam logic [3:0] BTS_FLAGS_OFS = 4'h0;
    localparam logic [3:0] BTS_STATUS_OFS = 4'h4;
    localparam logic [3:0] BTS_BASE_OFS = 4'h8;
    localparam logic [3:0] BTS_FLAGS_RST = 4'h0;

    // status word fields
    localparam int BTS_ST_BUSY = 0;
    localparam int BTS_ST_ABORT = 1;
    localparam int BTS_ST_SKIP = 2;
    localparam int BTS_ST_CNT_LO = 8;

    // instruction fields
    localparam int BTS_COND_LO = 28;
    localparam int BTS_PRE_BIT = 24;
    localparam int BTS_UP_BIT = 23;
    localparam int BTS_BANK_BIT = 22;
    localparam int BTS_WB_BIT = 21;
    localparam int BTS_LOAD_BIT = 20;
    localparam int BTS_BASE_LO = 16;

    localparam logic [3:0] BTS_PC_IDX = 4'hF;
    localparam logic [31:0] BTS_PC_ADJ = 32'h0000000C;
    localparam logic [31:0] BTS_WORD_STEP = 32'h00000004;
    localparam logic [1:0] BTS_FILL_CYCLES = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CALC = 5'b00010,
        ST_XFER = 5'b00100,
        ST_IWAIT = 5'b01000,
        ST_FILL = 5'b10000
    } bts_st_t;

    typedef struct packed {
        bts_st_t st;
        logic [15:0] remain;
        logic load;
        logic sbit;
        logic wbk;
        logic pc_in;
        logic user;
        logic [3:0] base_idx;
        logic [31:0] base_val;
        logic [31:0] wb_val;
        logic [31:0] pc_val;
        logic [31:0] lo_addr;
        logic [3:0] cur_idx;
        logic aborted;
        logic mem_req;
        logic mem_we;
        logic mem_seq;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic rf_we;
        logic [3:0] rf_waddr;
        logic [31:0] rf_wdata;
        logic psr_copy;
        logic trap;
        logic done;
        logic [1:0] fill;
        logic [5:0] cyc;
        logic [3:0] flags;
        logic last_abort;
        logic last_skip;
        logic [4:0] last_cnt;
        logic [31:0] rdata;
    } bts_state_t;

endpackage

// *** rtl/bts_sequencer.sv ***
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - run only when condition field passes; otherwise no transfer, no change
// - 16-bit mask, bit i selects register i
// - stored program counter equals instruction address plus 12
// - ascending register order, lowest register at lowest address
// - addresses from base value, pre/post bit and up/down bit
// - without write-back base keeps value unless loaded
// - low two address bits ignored for stepping but still output
// - banked load with program counter copies saved status at pc load
// - banked store with program counter reads user-bank registers
// - bank bit without program counter uses user bank both directions
// - write-back ends cycle two; store writes first word in cycle two
// - stored base is original if first, updated if later
// - loaded base value replaces written-back base
// - store abort: finish transfers, then trap; only base write-back
// - load abort drops aborting and later loads, keeps earlier ones
// - load abort restores base to written-back or original value
// - load abort trap only after whole sequence completes
// - cycles: load n+2, load with pc n+4 (n+2 if aborted), store n+1
// - pre/post and up/down give four address modes
// - write-back bit set stores final modified base
module bts_sequencer
    import bts_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] instr_addr_i,
    output logic busy_o,
    output logic done_o,
    output logic abort_trap_o,
    output logic [3:0] rf_raddr_o,
    input wire logic [31:0] rf_rdata_i,
    output logic rf_user_o,
    output logic rf_we_o,
    output logic [3:0] rf_waddr_o,
    output logic [31:0] rf_wdata_o,
    output logic psr_copy_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic mem_seq_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_abort_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o
);

    localparam bts_state_t RST_STATE = '{st: ST_IDLE, default: '0};

    default clocking bts_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        n = f[3];
        z = f[2];
        cy = f[1];
        v = f[0];
        unique case (c)
            4'h0: cond_ok = z;
            4'h1: cond_ok = !z;
            4'h2: cond_ok = cy;
            4'h3: cond_ok = !cy;
            4'h4: cond_ok = n;
            4'h5: cond_ok = !n;
            4'h6: cond_ok = v;
            4'h7: cond_ok = !v;
            4'h8: cond_ok = cy && !z;
            4'h9: cond_ok = !cy || z;
            4'hA: cond_ok = n == v;
            4'hB: cond_ok = n != v;
            4'hC: cond_ok = !z && (n == v);
            4'hD: cond_ok = z || (n != v);
            4'hE: cond_ok = 1'b1;
            default: cond_ok = 1'b0;
        endcase
    endfunction

    function automatic logic [4:0] pop16(input logic [15:0] m);
        pop16 = 5'h0;
        for (int i = 0; i < 16; i++) begin
            pop16 = pop16 + {4'h0, m[i]};
        end
    endfunction

    // lowest set bit: ascending register order
    function automatic logic [3:0] low_idx(input logic [15:0] m);
        low_idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (m[i]) begin
                low_idx = 4'(i);
            end
        end
    endfunction

    bts_state_t q;
    bts_state_t d;
    logic [3:0] idx;
    logic [31:0] sval;
    logic [31:0] off;
    logic [31:0] base;
    logic ab;

    always_comb begin
        d = q;
        d.rf_we = 1'b0;
        d.psr_copy = 1'b0;
        d.trap = 1'b0;
        d.done = 1'b0;
        d.rdata = 32'h0;
        idx = low_idx(q.remain);
        base = rf_rdata_i;
        off = {25'h0, pop16(instr_i[15:0]), 2'b00};
        ab = q.aborted | mem_abort_i;
        sval = rf_rdata_i;
        if (idx == BTS_PC_IDX) begin
            sval = q.pc_val;
        end else if (idx == q.base_idx && q.wbk && q.st != ST_CALC) begin
            sval = q.wb_val;
        end
        if (q.st != ST_IDLE) begin
            d.cyc = q.cyc + 6'h1;
        end
        unique case (q.st)
            ST_IDLE: begin
                if (start_i) begin
                    if (cond_ok(instr_i[31:BTS_COND_LO], q.flags) &&
                        instr_i[15:0] != 16'h0) begin
                        d.st = ST_CALC;
                        // zero here so done sees exactly the busy cycles
                        d.cyc = 6'h0;
                        d.last_skip = 1'b0;
                        d.remain = instr_i[15:0];
                        d.load = instr_i[BTS_LOAD_BIT];
                        d.sbit = instr_i[BTS_BANK_BIT];
                        d.wbk = instr_i[BTS_WB_BIT];
                        d.pc_in = instr_i[15];
                        d.user = instr_i[BTS_BANK_BIT] &&
                            (!instr_i[15] || !instr_i[BTS_LOAD_BIT]);
                        d.base_idx = instr_i[BTS_BASE_LO+3:BTS_BASE_LO];
                        d.base_val = base;
                        d.pc_val = instr_addr_i + BTS_PC_ADJ;
                        d.aborted = 1'b0;
                        d.last_cnt = pop16(instr_i[15:0]);
                        d.wb_val = instr_i[BTS_UP_BIT] ?
                            base + off : base - off;
                        if (instr_i[BTS_UP_BIT]) begin
                            d.lo_addr = instr_i[BTS_PRE_BIT] ?
                                base + BTS_WORD_STEP : base;
                        end else begin
                            d.lo_addr = instr_i[BTS_PRE_BIT] ?
                                base - off : base - off + BTS_WORD_STEP;
                        end
                    end else begin
                        d.last_skip = 1'b1;
                    end
                end
            end
            ST_CALC: begin
                d.st = ST_XFER;
                d.mem_req = 1'b1;
                d.mem_we = !q.load;
                d.mem_seq = 1'b0;
                d.mem_addr = q.lo_addr;
                d.cur_idx = idx;
                d.remain[idx] = 1'b0;
                d.mem_wdata = q.load ? 32'h0 : sval;
                if (q.wbk) begin
                    d.rf_we = 1'b1;
                    d.rf_waddr = q.base_idx;
                    d.rf_wdata = q.wb_val;
                end
            end
            ST_XFER: begin
                d.aborted = ab;
                if (q.load && !ab) begin
                    d.rf_we = 1'b1;
                    d.rf_waddr = q.cur_idx;
                    d.rf_wdata = mem_rdata_i;
                    d.psr_copy = q.sbit && q.cur_idx == BTS_PC_IDX;
                end
                if (q.remain != 16'h0) begin
                    d.mem_seq = 1'b1;
                    // step word part only; byte lane bits carried as-is
                    d.mem_addr = {q.mem_addr[31:2] + 30'h1, q.mem_addr[1:0]};
                    d.cur_idx = idx;
                    d.remain[idx] = 1'b0;
                    d.mem_wdata = q.load ? 32'h0 : sval;
                end else begin
                    d.mem_req = 1'b0;
                    d.mem_we = 1'b0;
                    d.mem_seq = 1'b0;
                    d.mem_wdata = 32'h0;
                    if (q.load) begin
                        d.st = ST_IWAIT;
                        if (ab) begin
                            d.rf_we = 1'b1;
                            d.rf_waddr = q.base_idx;
                            d.rf_wdata = q.wbk ? q.wb_val : q.base_val;
                        end
                    end else begin
                        d.st = ST_IDLE;
                        d.done = 1'b1;
                        d.trap = ab;
                        d.last_abort = ab;
                    end
                end
            end
            ST_IWAIT: begin
                d.fill = 2'h0;
                if (!q.aborted && q.pc_in) begin
                    d.st = ST_FILL;
                end else begin
                    d.st = ST_IDLE;
                    d.done = 1'b1;
                    d.trap = q.aborted;
                    d.last_abort = q.aborted;
                end
            end
            ST_FILL: begin
                d.fill = q.fill + 2'h1;
                if (q.fill == BTS_FILL_CYCLES - 2'h1) begin
                    d.st = ST_IDLE;
                    d.done = 1'b1;
                    d.last_abort = 1'b0;
                end
            end
            default: begin
                d = RST_STATE;
            end
        endcase
        if (reg_we_i && reg_addr_i == BTS_FLAGS_OFS) begin
            d.flags = reg_wdata_i[3:0];
        end
        if (reg_re_i) begin
            unique case (reg_addr_i)
                BTS_FLAGS_OFS: d.rdata = {28'h0, q.flags};
                BTS_STATUS_OFS: begin
                    d.rdata[BTS_ST_BUSY] = q.st != ST_IDLE;
                    d.rdata[BTS_ST_ABORT] = q.last_abort;
                    d.rdata[BTS_ST_SKIP] = q.last_skip;
                    d.rdata[BTS_ST_CNT_LO+4:BTS_ST_CNT_LO] = q.last_cnt;
                end
                BTS_BASE_OFS: d.rdata = q.wb_val;
                default: d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= RST_STATE;
            q.flags <= BTS_FLAGS_RST;
        end else begin
            q <= d;
        end
    end

    assign busy_o = q.st != ST_IDLE;
    assign done_o = q.done;
    assign abort_trap_o = q.trap;
    assign rf_raddr_o = (q.st == ST_IDLE) ?
        instr_i[BTS_BASE_LO+3:BTS_BASE_LO] : idx;
    assign rf_user_o = q.user && busy_o;
    assign rf_we_o = q.rf_we;
    assign rf_waddr_o = q.rf_waddr;
    assign rf_wdata_o = q.rf_wdata;
    assign psr_copy_o = q.psr_copy;
    assign mem_req_o = q.mem_req;
    assign mem_we_o = q.mem_we;
    assign mem_seq_o = q.mem_seq;
    assign mem_addr_o = q.mem_addr;
    assign mem_wdata_o = q.mem_wdata;
    assign reg_rdata_o = q.rdata;

    cond_skip_a: assert property (
        (!busy_o && start_i && !cond_ok(instr_i[31:BTS_COND_LO], q.flags))
        |=> (!busy_o && !rf_we_o && !mem_req_o))
        else $error("failed condition still started a transfer");
    pc_store_a: assert property (
        (mem_req_o && mem_we_o && q.cur_idx == BTS_PC_IDX)
        |-> mem_wdata_o == q.pc_val)
        else $error("stored program counter is wrong");
    addr_step_a: assert property (
        mem_seq_o |-> mem_addr_o == $past(mem_addr_o) + BTS_WORD_STEP)
        else $error("transfer address did not step by one word");
    asc_order_a: assert property (
        mem_seq_o |-> q.cur_idx > $past(q.cur_idx))
        else $error("registers not transferred in ascending order");
    wb_timing_a: assert property (
        (q.st == ST_CALC && q.wbk) |=> (rf_we_o && rf_waddr_o == q.base_idx
        && rf_wdata_o == q.wb_val && mem_req_o && !mem_seq_o))
        else $error("base write-back not in second cycle");
    psr_copy_a: assert property (
        psr_copy_o |-> (rf_we_o && rf_waddr_o == BTS_PC_IDX && q.sbit))
        else $error("status copy without program counter load");
    load_drop_a: assert property (
        (q.st == ST_XFER && q.load && ab)
        |=> !(rf_we_o && rf_waddr_o != q.base_idx) && !psr_copy_o)
        else $error("register written after load abort");
    user_bank_a: assert property (
        (busy_o && q.sbit && !q.pc_in) |-> rf_user_o)
        else $error("user bank not selected");
    cycle_cnt_a: assert property (
        (done_o && !(q.load && q.aborted)) |-> q.cyc == ({1'b0, q.last_cnt}
        + (!q.load ? 6'h1 : (q.pc_in ? 6'h4 : 6'h2))))
        else $error("instruction cycle count wrong");
    trap_end_a: assert property (
        abort_trap_o |-> (done_o && !busy_o &&
        $past(q.aborted || mem_abort_i)))
        else $error("abort trap outside instruction end");
    base_restore_a: assert property (
        (q.st == ST_IWAIT && q.aborted) |-> (rf_we_o &&
        rf_waddr_o == q.base_idx &&
        rf_wdata_o == (q.wbk ? q.wb_val : q.base_val)))
        else $error("base not restored after load abort");
    store_state_a: assert property (
        (q.st == ST_XFER && !q.load) |=> (!rf_we_o && !psr_copy_o))
        else $error("store changed a register after its first cycle");
    base_first_a: assert property (
        (q.st == ST_CALC && !q.load && !q.user && idx == q.base_idx)
        |=> mem_wdata_o == q.base_val)
        else $error("first stored base is not the original value");
    no_wb_a: assert property (
        (q.st == ST_CALC && !q.wbk) |=> !rf_we_o)
        else $error("base written without write-back");

endmodule

// *** verif/bts_mem_model.sv ***
`timescale 1ns/10ps
module bts_mem_model (
    input wire logic clk_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic [31:0] mem_rdata_o,
    output logic mem_abort_o,
    input wire logic abort_en_i,
    input wire logic [31:0] abort_addr_i
);
    logic [31:0] mem [0:63];
    logic [31:0] last_q = 32'h0;

    // rejects only the word the bench commands
    assign mem_abort_o = mem_req_i && abort_en_i &&
        (mem_addr_i[7:2] == abort_addr_i[7:2]);
    // idle bus shows the inverse so stale data never looks valid
    assign mem_rdata_o = mem_req_i ? mem[mem_addr_i[7:2]] : ~last_q;

    always @(posedge clk_i) begin
        if (mem_req_i) begin
            last_q <= mem_rdata_o;
        end
        // an aborted store never reaches the array
        if (mem_req_i && mem_we_i && !mem_abort_o) begin
            mem[mem_addr_i[7:2]] <= mem_wdata_i;
        end
    end
endmodule

// *** verif/tb_block_transfer_sequencer.sv ***
`timescale 1ns/10ps
module tb_block_transfer_sequencer;
    import bts_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [31:0] instr_addr_i = 32'h0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic abort_en = 1'b0;
    logic [31:0] abort_addr = 32'h0;
    logic busy_o, done_o, abort_trap_o, rf_user_o, rf_we_o, psr_copy_o;
    logic mem_req_o, mem_we_o, mem_seq_o, mem_abort_i;
    logic [3:0] rf_raddr_o, rf_waddr_o;
    logic [31:0] rf_rdata_i, rf_wdata_o, mem_addr_o, mem_wdata_o;
    logic [31:0] mem_rdata_i, reg_rdata_o;
    logic [31:0] rf [0:15], ub [0:15], erf [0:15], eub [0:15];
    logic [31:0] emem [0:63], eaddr [0:15], edata [0:15];
    logic eld = 1'b0;
    int num_errors = 0, samples_checked = 0, seed = 25;
    int xi = 0, nbusy = 0, psr_cnt = 0;

    always #2.5 clk_i = ~clk_i;
    assign rf_rdata_i = rf_user_o ? ub[rf_raddr_o] : rf[rf_raddr_o];

    bts_sequencer i_bts_sequencer (.clk_i(clk_i), .rst_i(rst_i),
        .start_i(start_i), .instr_i(instr_i), .instr_addr_i(instr_addr_i),
        .busy_o(busy_o), .done_o(done_o), .abort_trap_o(abort_trap_o),
        .rf_raddr_o(rf_raddr_o), .rf_rdata_i(rf_rdata_i),
        .rf_user_o(rf_user_o), .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o),
        .rf_wdata_o(rf_wdata_o), .psr_copy_o(psr_copy_o),
        .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_seq_o(mem_seq_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .mem_abort_i(mem_abort_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

    bts_mem_model i_bts_mem_model (.clk_i(clk_i), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
        .mem_abort_o(mem_abort_i), .abort_en_i(abort_en),
        .abort_addr_i(abort_addr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        if (rf_we_o === 1'b1) begin
            if (rf_user_o) ub[rf_waddr_o] <= rf_wdata_o;
            else rf[rf_waddr_o] <= rf_wdata_o;
        end
        if (busy_o === 1'b1) nbusy++;
        if (psr_copy_o === 1'b1) begin
            psr_cnt++;
            check({rf_we_o, rf_waddr_o}, 32'h1F);
        end
        if (mem_req_o === 1'b1) begin
            check(mem_addr_o,
                eaddr[xi[3:0]]);
            check(mem_wdata_o, edata[xi[3:0]]);
            check({mem_we_o, mem_seq_o}, {!eld, xi != 0});
            xi++;
        end
    end

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(negedge clk_i);
        v = reg_rdata_o;
    endtask

    function automatic logic [31:0] mk(input logic [4:0] f,
            input logic [3:0] b, input logic [15:0] m);
        return {4'hE, 3'b100, f, b, m};
    endfunction

    // flags are n, z, c, v from bit 3 down
    function automatic bit cond_pass(input logic [3:0] c,
            input logic [3:0] f);
        bit t;
        case (c[3:1])
            3'h0: t = f[2];
            3'h1: t = f[1];
            3'h2: t = f[3];
            3'h3: t = f[0];
            3'h4: t = f[1] && !f[2];
            3'h5: t = f[3] == f[0];
            3'h6: t = !f[2] && (f[3] == f[0]);
            default: t = !c[0];
        endcase
        return (c[3:1] == 3'h7) ? t : t ^ c[0];
    endfunction

    // works out the whole outcome first, then runs and compares
    task automatic run(input logic [31:0] ins, input int ak, input bit skip);
        logic [3:0] b;
        logic [31:0] wb, lo, ia, v;
        int n, k, t, ecyc, epsr;
        b = ins[19:16];
        eld = ins[20];
        ia = $random(seed) & 32'hFFFFFFFC;
        rf[b] = 32'h80 + ($random(seed) & 3);
        ub[b] = rf[b];
        n = $countones(ins[15:0]);
        wb = ins[23] ? rf[b] + 4 * n : rf[b] - 4 * n;
        lo = ins[23] ? rf[b] + (ins[24] ? 4 : 0) : wb + (ins[24] ? 0 : 4);
        erf = rf;
        eub = ub;
        emem = i_bts_mem_model.mem;
        k = 0;
        for (int i = 0; i < 16; i++) begin
            if (ins[i] && !skip) begin
                eaddr[k] = lo + 4 * k;
                v = (i == 15) ? ia + BTS_PC_ADJ : (ins[22] ? ub[i] : rf[i]);
                if (i == b && ins[21] && k != 0) v = wb;
                edata[k] = eld ? 32'h0 : v;
                if (!eld && k != ak) emem[eaddr[k][7:2]] = v;
                if (eld && k < ak && ins[22] && !ins[15]) begin
                    eub[i] = emem[eaddr[k][7:2]];
                end else if (eld && k < ak) begin
                    erf[i] = emem[eaddr[k][7:2]];
                end
                k++;
            end
        end
        if (!skip && ins[21] && !(eld && ins[b] && ak >= n)) erf[b] = wb;
        if (!skip && eld && ak < n && !ins[21]) erf[b] = rf[b];
        ecyc = skip ? 0 : !eld ? n + 1 : (ins[15] && ak >= n) ? n + 4 : n + 2;
        epsr = !skip && eld && ins[22] && ins[15] && ak >= n;
        @(posedge clk_i);
        xi = 0;
        nbusy = 0;
        psr_cnt = 0;
        abort_en <= ak < n;
        abort_addr <= lo + 4 * ak;
        instr_i <= ins;
        instr_addr_i <= ia;
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        for (t = 0; t < 60; t++) begin
            @(negedge clk_i);
            if (done_o === 1'b1 || (skip && t == 8)) break;
        end
        if (!skip && t == 60) begin
            num_errors++;
            give_verdict;
        end
        check(done_o, !skip);
        check(abort_trap_o, !skip && ak < n);
        check(nbusy, ecyc);
        check(psr_cnt, epsr);
        check(xi, skip ? 0 : n);
        for (int i = 0; i < 16; i++) begin
            check(rf[i],
                erf[i]);
            check(ub[i], eub[i]);
        end
        for (int i = 0; i < 64; i++) begin
            check(i_bts_mem_model.mem[i], emem[i]);
        end
        if (!skip) begin
            reg_rd(BTS_BASE_OFS, v);
            check(v, wb);
            reg_rd(BTS_STATUS_OFS, v);
            check(v, {19'h0, n[4:0], 6'h0, ak < n, 1'b0});
        end
    endtask

    initial begin
        logic [31:0] r, v;
        logic [15:0] m;
        logic [3:0] b;
        int ak;
        for (int i = 0; i < 16; i++) begin
            rf[i] = $random(seed);
            ub[i] = $random(seed);
        end
        for (int i = 0; i < 64; i++) i_bts_mem_model.mem[i] = $random(seed);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_rd(BTS_FLAGS_OFS, v);
        check(v, 32'h0);
        reg_wr(4'hC, 32'hA5A5A5A5);
        reg_rd(4'hC, v);
        check(v, 32'h0);
        reg_wr(BTS_FLAGS_OFS, 32'h4);
        reg_rd(BTS_FLAGS_OFS, v);
        check(v, 32'h4);
        // zero flag set: not-equal is skipped, equal runs
        r = mk(5'b01010, 4'h1, 16'h0006);
        run({4'h1, r[27:0]}, 99, 1'b1);
        reg_rd(BTS_STATUS_OFS, v);
        check(v[BTS_ST_SKIP], 1'b1);
        run({4'h0, r[27:0]}, 99, 1'b0);
        run(mk(5'b01010, 4'h1, 16'h8003), 99, 1'b0);
        run(mk(5'b10010, 4'h2, 16'h0006), 99, 1'b0);
        run(mk(5'b01011, 4'h1, 16'h0007), 99, 1'b0);
        run(mk(5'b11101, 4'h3, 16'h8011), 99, 1'b0);
        run(mk(5'b00101, 4'h3, 16'h00F0), 99, 1'b0);
        run(mk(5'b01100, 4'h3, 16'h80F0), 99, 1'b0);
        run(mk(5'b01000, 4'h0, 16'hFFFF), 99, 1'b0);
        run(mk(5'b00010, 4'h4, 16'h1248), 99, 1'b0);
        run(mk(5'b01001, 4'h2, 16'h800C), 2, 1'b0);
        run(mk(5'b10011, 4'h2, 16'h0F04), 1, 1'b0);
        run(mk(5'b01010, 4'h5, 16'h00FF), 3, 1'b0);
        // every condition code against random flags
        for (int i = 0; i < 16; i++) begin
            m = 16'($random(seed));
            reg_wr(BTS_FLAGS_OFS, {28'h0, m[3:0]});
            r = mk(5'b01010, 4'h1, 16'h0006);
            run({4'(i), r[27:0]}, 99, !cond_pass(4'(i), m[3:0]));
        end
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            m = (r[15:0] == 16'h0) ? 16'h0001 : r[15:0];
            b = (r[19:16] == 4'hF) ? 4'hD : r[19:16];
            ak = (r[31:30] == 2'b00) ? int'(r[27:24]) : 99;
            run(mk({r[20], r[21], 1'b0, r[22], r[23]}, b, m), ak, 1'b0);
        end
        give_verdict;
    end
endmodule
